// *** inc/cas_pkg.sv ***
// Shared constants, types and flag arithmetic of the core ALU status block.
package cas_pkg;

    localparam logic [7:0] PSW_ADDR  = 8'hd0;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam int         CY_BIT    = 7;
    localparam int         AC_BIT    = 6;
    localparam int         F0_BIT    = 5;
    localparam int         BANK_HI   = 4;
    localparam int         BANK_LO   = 3;
    localparam int         OV_BIT    = 2;
    localparam int         F1_BIT    = 1;
    localparam int         PAR_BIT   = 0;

    localparam int         LEN_W     = 2;
    localparam int         CYC_W     = 4;
    localparam int         BANK_W    = 5;
    localparam logic [LEN_W-1:0] LEN1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN3 = 2'h3;
    localparam logic [CYC_W-1:0] CYC1 = 4'h1;
    localparam logic [CYC_W-1:0] CYC2 = 4'h2;
    localparam logic [CYC_W-1:0] CYC3 = 4'h3;
    localparam logic [CYC_W-1:0] CYC_MUL = 4'h4;
    localparam logic [CYC_W-1:0] CYC_DIV = 4'h8;

    localparam logic [7:0] DIV_ZERO_QUOT = 8'hff;
    localparam logic [3:0] BCD_MAX       = 4'h9;
    localparam logic [8:0] BCD_ADJ_LO    = 9'h006;
    localparam logic [8:0] BCD_ADJ_HI    = 9'h060;

    typedef enum logic [3:0] {
        OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC, OP_INC_DATA_POINTER,
        OP_MUL, OP_DIV, OP_DA, OP_AND, OP_OR, OP_XOR
    } cas_op_e;

    typedef enum logic [2:0] {
        FORM_REG, FORM_DIRECT, FORM_INDIRECT, FORM_IMM, FORM_ACC, FORM_DIR_A, FORM_DIR_IMM
    } cas_form_e;

    // Returns carry, half carry, signed overflow and the byte sum.
    function automatic logic [10:0] cas_add(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], lo[4], (a[7] == b[7]) && (full[7] != a[7]), full[7:0]};
    endfunction : cas_add

    // Returns borrow, half borrow, signed overflow and the byte difference.
    function automatic logic [10:0] cas_sub(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        return {full[8], lo[4], (a[7] != b[7]) && (full[7] != a[7]), full[7:0]};
    endfunction : cas_sub

endpackage : cas_pkg

// *** inc/cas_timing_if.sv ***
// Instruction length and cycle count lookup carrier.
`timescale 1ns/1ps
interface cas_timing_if;
    import cas_pkg::*;
    cas_op_e          op;
    cas_form_e        form;
    logic [LEN_W-1:0] bytes;
    logic [CYC_W-1:0] cycles;
    modport lookup (input op, input form, output bytes, output cycles);
    modport user   (output op, output form, input bytes, input cycles);
endinterface : cas_timing_if

// *** verilog/cas_alu_timing.sv ***
// Byte length and cycle count of each ALU instruction form.
`timescale 1ns/1ps
module cas_alu_timing
    import cas_pkg::*;
(
    cas_timing_if.lookup tif
);

    always_comb begin
        tif.bytes  = LEN1;
        tif.cycles = CYC1;
        unique case (tif.op)
            OP_MUL: begin
                tif.cycles = CYC_MUL;
            end
            OP_DIV: begin
                tif.cycles = CYC_DIV;
            end
            OP_DA, OP_INC_DATA_POINTER: begin
                tif.cycles = CYC1;
            end
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC, OP_AND, OP_OR, OP_XOR: begin
                // Exclusive-OR forms beyond the register one reuse the AND timing.
                unique case (tif.form)
                    FORM_REG, FORM_ACC: begin
                        tif.bytes  = LEN1;
                        tif.cycles = CYC1;
                    end
                    FORM_DIRECT, FORM_IMM, FORM_DIR_A: begin
                        tif.bytes  = LEN2;
                        tif.cycles = CYC2;
                    end
                    FORM_INDIRECT: begin
                        tif.bytes  = LEN1;
                        tif.cycles = CYC2;
                    end
                    FORM_DIR_IMM: begin
                        tif.bytes  = LEN3;
                        tif.cycles = CYC3;
                    end
                endcase
            end
        endcase
    end

endmodule : cas_alu_timing

// *** verilog/cas_alu_top.sv ***
// ALU sequencing and program status word of the 8-bit core.
`timescale 1ns/1ps
module cas_alu_top
    import cas_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              start_i,
    input  wire cas_op_e           op_i,
    input  wire cas_form_e         form_i,
    input  wire logic [7:0]        a_i,
    input  wire logic [7:0]        b_i,
    input  wire logic [15:0]       data_pointer_i,
    input  wire logic [7:0]        acc_i,
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic              sfr_wr_i,
    input  wire logic [7:0]        sfr_wdata_i,
    input  wire logic              sfr_bit_wr_i,
    input  wire logic [2:0]        sfr_bit_sel_i,
    input  wire logic              sfr_bit_val_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic [15:0]            result_o,
    output logic [LEN_W-1:0]       length_o,
    output logic [7:0]             psw_o,
    output logic [BANK_W-1:0]      bank_base_o,
    output logic [7:0]             sfr_rdata_o
);

    typedef enum logic {ST_IDLE, ST_BUSY} cas_state_e;

    cas_state_e       state,      next_state;
    logic [CYC_W-1:0] cnt,        next_cnt;
    logic [15:0]      pend_res,   next_pend_res;
    logic [2:0]       pend_flg,   next_pend_flg;
    logic [2:0]       pend_msk,   next_pend_msk;
    logic             next_busy;
    logic             next_done;
    logic [15:0]      next_result;
    logic [LEN_W-1:0] next_length;
    logic [7:0]       next_psw;
    logic [BANK_W-1:0] next_bank_base;
    logic [7:0]       next_rdata;

    logic [15:0]      c_res;
    logic [2:0]       c_flg;
    logic [2:0]       c_msk;
    logic [10:0]      ar;
    logic [15:0]      prod;
    logic [8:0]       da_t;
    logic             da_c;
    logic [15:0]      k_res;
    logic [2:0]       k_flg;
    logic [2:0]       k_msk;
    logic             commit;
    logic             psw_sel;
    logic             accept;

    cas_timing_if tif ();
    assign tif.op   = op_i;
    assign tif.form = form_i;
    cas_alu_timing u_timing (.tif(tif.lookup));

    assign psw_sel = (sfr_addr_i == PSW_ADDR);
    assign accept  = (state == ST_IDLE) && start_i;

    // Operation result; flags packed as {carry, half carry, overflow}, mask says which update.
    always_comb begin
        c_res = 16'h0000;
        c_flg = 3'h0;
        c_msk = 3'h0;
        ar    = 11'h000;
        prod  = {8'h00, a_i} * {8'h00, b_i};
        da_t  = {1'b0, a_i};
        da_c  = psw_o[CY_BIT];
        unique case (op_i)
            OP_ADD, OP_ADD_WITH_CARRY: begin
                ar    = cas_add(a_i, b_i, (op_i == OP_ADD_WITH_CARRY) && psw_o[CY_BIT]);
                c_res = {8'h00, ar[7:0]};
                c_flg = ar[10:8];
                c_msk = 3'h7;
            end
            OP_SUBTRACT_WITH_BORROW: begin
                ar    = cas_sub(a_i, b_i, psw_o[CY_BIT]);
                c_res = {8'h00, ar[7:0]};
                c_flg = ar[10:8];
                c_msk = 3'h7;
            end
            OP_INC:      c_res = {8'h00, a_i + 8'h01};
            OP_DEC:      c_res = {8'h00, a_i - 8'h01};
            OP_INC_DATA_POINTER: c_res = data_pointer_i + 16'h0001;
            OP_MUL: begin
                c_res = prod;
                c_flg = {1'b0, 1'b0, prod[15:8] != 8'h00};
                c_msk = 3'h5;
            end
            OP_DIV: begin
                // A zero divisor gives an all-ones quotient and keeps the dividend as remainder.
                c_res = (b_i == 8'h00) ? {a_i, DIV_ZERO_QUOT} : {a_i % b_i, a_i / b_i};
                c_flg = 3'h0;
                c_msk = 3'h5;
            end
            OP_DA: begin
                if ((a_i[3:0] > BCD_MAX) || psw_o[AC_BIT]) begin
                    da_t = da_t + BCD_ADJ_LO;
                end
                da_c = da_c | da_t[8];
                if ((da_t[7:4] > BCD_MAX) || da_c) begin
                    da_t = {1'b0, da_t[7:0]} + BCD_ADJ_HI;
                end
                c_res = {8'h00, da_t[7:0]};
                c_flg = {da_c | da_t[8], 2'h0};
                c_msk = 3'h4;
            end
            OP_AND: c_res = {8'h00, a_i & b_i};
            OP_OR:  c_res = {8'h00, a_i | b_i};
            OP_XOR: c_res = {8'h00, a_i ^ b_i};
        endcase
    end

    // Sequencer and status word next values.
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_pend_res  = pend_res;
        next_pend_flg  = pend_flg;
        next_pend_msk  = pend_msk;
        next_done      = 1'b0;
        next_result    = result_o;
        next_length    = length_o;
        next_psw       = psw_o;
        commit         = 1'b0;
        k_res          = pend_res;
        k_flg          = pend_flg;
        k_msk          = pend_msk;
        unique case (state)
            ST_IDLE: begin
                if (start_i) begin
                    next_pend_res = c_res;
                    next_pend_flg = c_flg;
                    next_pend_msk = c_msk;
                    next_length   = tif.bytes;
                    if (tif.cycles == CYC1) begin
                        commit = 1'b1;
                        k_res  = c_res;
                        k_flg  = c_flg;
                        k_msk  = c_msk;
                    end else begin
                        next_state = ST_BUSY;
                        next_cnt   = tif.cycles - CYC1;
                    end
                end
            end
            ST_BUSY: begin
                next_cnt = cnt - CYC1;
                if (cnt == CYC1) begin
                    commit     = 1'b1;
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (psw_sel && sfr_wr_i) begin
            next_psw = sfr_wdata_i;
        end else if (psw_sel && sfr_bit_wr_i) begin
            next_psw[sfr_bit_sel_i] = sfr_bit_val_i;
        end
        // A completing instruction overrides a same-cycle software write of its flags.
        if (commit) begin
            next_done   = 1'b1;
            next_result = k_res;
            if (k_msk[2]) next_psw[CY_BIT] = k_flg[2];
            if (k_msk[1]) next_psw[AC_BIT] = k_flg[1];
            if (k_msk[0]) next_psw[OV_BIT] = k_flg[0];
        end
        next_psw[PAR_BIT] = ^acc_i;
        next_busy         = (next_state == ST_BUSY);
        next_bank_base    = {next_psw[BANK_HI:BANK_LO], 3'h0};
        next_rdata        = psw_sel ? psw_o : 8'h00;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state       <= ST_IDLE;
            cnt         <= '0;
            pend_res    <= 16'h0000;
            pend_flg    <= 3'h0;
            pend_msk    <= 3'h0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            result_o    <= 16'h0000;
            length_o    <= '0;
            psw_o       <= PSW_RESET;
            bank_base_o <= '0;
            sfr_rdata_o <= 8'h00;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            pend_res    <= next_pend_res;
            pend_flg    <= next_pend_flg;
            pend_msk    <= next_pend_msk;
            busy_o      <= next_busy;
            done_o      <= next_done;
            result_o    <= next_result;
            length_o    <= next_length;
            psw_o       <= next_psw;
            bank_base_o <= next_bank_base;
            sfr_rdata_o <= next_rdata;
        end
    end

    property p_add_reg;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_ADD && form_i == FORM_REG |=> done_o && length_o == LEN1;
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add reg timing wrong");
    property p_add_ind;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_ADD && form_i == FORM_INDIRECT |=> !done_o ##1 done_o && length_o == LEN1;
    endproperty
    a_add_ind: assert property (p_add_ind) else $error("add indirect timing wrong");
    property p_add_with_carry_dir;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_ADD_WITH_CARRY && form_i == FORM_DIRECT |=> !done_o ##1 done_o && length_o == LEN2;
    endproperty
    a_add_with_carry_dir: assert property (p_add_with_carry_dir) else $error("add_with_carry direct timing wrong");
    property p_subtract_with_borrow_imm;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_SUBTRACT_WITH_BORROW && form_i == FORM_IMM |=> !done_o ##1 done_o;
    endproperty
    a_subtract_with_borrow_imm: assert property (p_subtract_with_borrow_imm) else $error("subtract_with_borrow immediate timing wrong");
    property p_dec_dir;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_DEC && form_i == FORM_DIRECT |=> !done_o ##1 done_o && length_o == LEN2;
    endproperty
    a_dec_dir: assert property (p_dec_dir) else $error("dec direct timing wrong");
    property p_data_pointer;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_INC_DATA_POINTER |=> done_o && result_o == $past(data_pointer_i) + 16'h0001;
    endproperty
    a_data_pointer: assert property (p_data_pointer) else $error("pointer increment wrong");
    property p_mul;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_MUL |=> !done_o [*3] ##1 done_o;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply timing wrong");
    property p_div;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_DIV |=> !done_o [*7] ##1 (done_o && !psw_o[OV_BIT] && !psw_o[CY_BIT]);
    endproperty
    a_div: assert property (p_div) else $error("divide timing or flags wrong");
    property p_da;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_DA |=> done_o;
    endproperty
    a_da: assert property (p_da) else $error("decimal adjust timing wrong");
    property p_and_dimm;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_AND && form_i == FORM_DIR_IMM |=> !done_o [*2] ##1 (done_o && length_o == LEN3);
    endproperty
    a_and_dimm: assert property (p_and_dimm) else $error("and direct immediate wrong");
    property p_xor;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_XOR && form_i == FORM_REG |=> done_o && result_o[7:0] == $past(a_i ^ b_i);
    endproperty
    a_xor: assert property (p_xor) else $error("xor register wrong");
    property p_carry;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_ADD && form_i == FORM_REG |=>
            psw_o[CY_BIT] == $past(({1'b0, a_i} + {1'b0, b_i}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_half;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_ADD && form_i == FORM_REG |=>
            psw_o[AC_BIT] == $past(({1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}) > 5'h0f);
    endproperty
    a_half: assert property (p_half) else $error("half carry flag wrong");
    property p_user;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !(psw_sel && (sfr_wr_i || sfr_bit_wr_i)) |=> $stable({psw_o[F0_BIT], psw_o[F1_BIT]});
    endproperty
    a_user: assert property (p_user) else $error("user flag changed by hardware");
    property p_bank;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        bank_base_o == {psw_o[BANK_HI:BANK_LO], 3'h0};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base mismatch");
    property p_mul_ov;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_MUL |-> ##4 psw_o[OV_BIT] == $past(prod[15:8] != 8'h00, 4);
    endproperty
    a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong");
    property p_parity;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> psw_o[PAR_BIT] == ^$past(acc_i);
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    property p_read;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        psw_sel |=> sfr_rdata_o == $past(psw_o);
    endproperty
    a_read: assert property (p_read) else $error("status word read wrong");
    property p_flag_time;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $changed(psw_o[CY_BIT]) |-> done_o || $past(psw_sel && (sfr_wr_i || sfr_bit_wr_i));
    endproperty
    a_flag_time: assert property (p_flag_time) else $error("carry changed off completion");

    c_mul: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_MUL ##4 psw_o[OV_BIT]);
    c_div0: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        accept && op_i == OP_DIV && b_i == 8'h00);
    c_bitwr: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        psw_sel && sfr_bit_wr_i && sfr_bit_sel_i == 3'h3);

endmodule : cas_alu_top

// *** test/cas_seq_model.sv ***
// Behavioural model of the instruction sequencer that feeds the ALU block.
`timescale 1ns/1ps
module cas_seq_model
    import cas_pkg::*;
(
    input  wire logic   ref_clk_i,
    input  wire logic   busy_i,
    input  wire logic   done_i,
    output logic        start_o,
    output cas_op_e     op_o,
    output cas_form_e   form_o,
    output logic [7:0]  a_o,
    output logic [7:0]  b_o,
    output logic [15:0] data_pointer_o
);
    initial begin
        start_o = 1'b0;
        op_o = OP_ADD;
        form_o = FORM_REG;
        a_o = 8'h00;
        b_o = 8'h00;
        data_pointer_o = 16'h0000;
    end

    // Operands are inverted after the taking edge so that late sampling shows up.
    task automatic issue(input cas_op_e op, input cas_form_e form, input logic [7:0] a,
                         input logic [7:0] b, output int cyc);
        int n;
        n = 1;
        @(posedge ref_clk_i);
        #1;
        start_o = 1'b1;
        op_o = op;
        form_o = form;
        a_o = a;
        b_o = b;
        data_pointer_o = {a, b};
        @(posedge ref_clk_i);
        #1;
        start_o = 1'b0;
        a_o = ~a;
        b_o = ~b;
        data_pointer_o = ~{a, b};
        while (done_i !== 1'b1 && n < 16) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        cyc = n;
    endtask : issue
endmodule : cas_seq_model

// *** test/testbench.sv ***
// Self-checking bench of the ALU sequencing and status word block.
`timescale 1ns/1ps
module testbench
    import cas_pkg::*;
();
    logic ref_clk_i, rstn_i, start, busy, done, wr_en, bit_wr, bit_val;
    cas_op_e op;
    cas_form_e form;
    logic [7:0] a, b, acc, sfr_addr, sfr_wdata, program_status_word, rdata;
    logic [15:0] data_pointer, result;
    logic [2:0] bit_sel;
    logic [LEN_W-1:0] length;
    logic [BANK_W-1:0] bank_base;
    int miscompares, total_checks, cycles;

    cas_seq_model u_seq (.ref_clk_i(ref_clk_i), .busy_i(busy), .done_i(done), .start_o(start),
        .op_o(op), .form_o(form), .a_o(a), .b_o(b), .data_pointer_o(data_pointer));

    cas_alu_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start), .op_i(op),
        .form_i(form), .a_i(a), .b_i(b), .data_pointer_i(data_pointer), .acc_i(acc), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(wr_en), .sfr_wdata_i(sfr_wdata), .sfr_bit_wr_i(bit_wr),
        .sfr_bit_sel_i(bit_sel), .sfr_bit_val_i(bit_val), .busy_o(busy), .done_o(done),
        .result_o(result), .length_o(length), .psw_o(program_status_word), .bank_base_o(bank_base),
        .sfr_rdata_o(rdata));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // The whole run needs about 130 cycles; the ceiling leaves a wide margin.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tm(input cas_op_e o, input cas_form_e f, input logic [3:0] len,
                      input logic [3:0] cyc);
        int n;
        u_seq.issue(o, f, 8'h12, 8'h34, n);
        check("length", 16'(len), 16'(length));
        check("cycles", 16'(cyc), 16'(n));
        check("busy", 16'h0000, {15'h0000, busy});
    endtask : tm

    task automatic ar(input cas_op_e o, input logic [7:0] x, input logic [7:0] y,
                      input logic [15:0] res, input logic [2:0] fl, input logic [2:0] m);
        int n;
        u_seq.issue(o, FORM_REG, x, y, n);
        check("result", res, (o == OP_MUL || o == OP_DIV) ? result : {8'h00, result[7:0]});
        check("flags", 16'(fl & m), 16'({program_status_word[CY_BIT], program_status_word[AC_BIT], program_status_word[OV_BIT]} & m));
    endtask : ar

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data, input logic bw);
        @(posedge ref_clk_i);
        #1;
        sfr_addr = addr;
        sfr_wdata = data;
        bit_sel = data[2:0];
        bit_val = data[7];
        wr_en = ~bw;
        bit_wr = bw;
        @(posedge ref_clk_i);
        #1;
        wr_en = 1'b0;
        bit_wr = 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk_i);
        #1;
        sfr_addr = addr;
        @(posedge ref_clk_i);
        #1;
        check("read", {8'h00, exp}, {8'h00, rdata});
    endtask : sfr_read

    task automatic t_timing();
        tm(OP_ADD, FORM_REG, 4'h1, 4'h1);
        tm(OP_ADD, FORM_DIRECT, 4'h2, 4'h2);
        tm(OP_ADD, FORM_INDIRECT, 4'h1, 4'h2);
        tm(OP_ADD_WITH_CARRY, FORM_IMM, 4'h2, 4'h2);
        tm(OP_SUBTRACT_WITH_BORROW, FORM_REG, 4'h1, 4'h1);
        tm(OP_SUBTRACT_WITH_BORROW, FORM_INDIRECT, 4'h1, 4'h2);
        tm(OP_INC, FORM_ACC, 4'h1, 4'h1);
        tm(OP_DEC, FORM_DIRECT, 4'h2, 4'h2);
        tm(OP_INC, FORM_INDIRECT, 4'h1, 4'h2);
        tm(OP_INC_DATA_POINTER, FORM_REG, 4'h1, 4'h1);
        check("data_pointer", 16'h1235, result);
        tm(OP_MUL, FORM_REG, 4'h1, 4'h4);
        check("mul", 16'h03a8, result);
        tm(OP_DIV, FORM_REG, 4'h1, 4'h8);
        check("div", 16'h1200, result);
        tm(OP_DA, FORM_REG, 4'h1, 4'h1);
        tm(OP_AND, FORM_DIR_A, 4'h2, 4'h2);
        tm(OP_OR, FORM_DIR_IMM, 4'h3, 4'h3);
        tm(OP_XOR, FORM_REG, 4'h1, 4'h1);
        check("xor", 16'h0026, {8'h00, result[7:0]});
    endtask : t_timing

    task automatic t_flags();
        ar(OP_ADD, 8'h7f, 8'h01, 16'h0080, 3'b011, 3'b111);
        ar(OP_ADD, 8'hff, 8'h01, 16'h0000, 3'b110, 3'b111);
        ar(OP_ADD_WITH_CARRY, 8'h10, 8'h20, 16'h0031, 3'b000, 3'b111);
        ar(OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01, 16'h00ff, 3'b110, 3'b111);
        ar(OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h01, 16'h007e, 3'b011, 3'b111);
        ar(OP_MUL, 8'h20, 8'h10, 16'h0200, 3'b001, 3'b101);
        ar(OP_MUL, 8'h03, 8'h04, 16'h000c, 3'b000, 3'b101);
        ar(OP_MUL, 8'h20, 8'h10, 16'h0200, 3'b001, 3'b101);
        ar(OP_DIV, 8'h64, 8'h07, 16'h020e, 3'b000, 3'b101);
        ar(OP_DA, 8'h7d, 8'h00, 16'h0083, 3'b000, 3'b100);
        // Half carry is still set from the earlier subtract, so the low nibble gets adjusted too.
        ar(OP_DA, 8'ha0, 8'h00, 16'h0006, 3'b100, 3'b100);
    endtask : t_flags

    task automatic t_status();
        acc = 8'h01;
        sfr_write(PSW_ADDR, 8'hff, 1'b0);
        check("psw", 16'h00ff, 16'(program_status_word));
        sfr_write(PSW_ADDR, 8'h00, 1'b0);
        check("psw", 16'h0001, 16'(program_status_word));
        for (int i = 0; i < 4; i++) begin
            sfr_write(PSW_ADDR, 8'(i * 8), 1'b0);
            check("bank", 16'(i * 8), 16'(bank_base));
        end
        sfr_write(PSW_ADDR, 8'h85, 1'b1);
        sfr_write(PSW_ADDR, 8'h81, 1'b1);
        check("psw", 16'h003b, 16'(program_status_word));
        sfr_read(PSW_ADDR, 8'h3b);
        sfr_read(8'he6, 8'h00);
        sfr_write(8'he6, 8'hc4, 1'b0);
        ar(OP_ADD, 8'h01, 8'h01, 16'h0002, 3'b000, 3'b111);
        check("psw", 16'h003b, 16'(program_status_word));
        acc = 8'h03;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("parity", 16'h003a, 16'(program_status_word));
    endtask : t_status

    initial begin
        miscompares = 0;
        total_checks = 0;
        cycles = 0;
        rstn_i = 1'b0;
        acc = 8'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        wr_en = 1'b0;
        bit_wr = 1'b0;
        bit_sel = 3'h0;
        bit_val = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        check("reset", {8'h00, PSW_RESET}, 16'(program_status_word));
        #1;
        rstn_i = 1'b1;
        t_timing();
        t_flags();
        t_status();
        tally_and_finish();
    end
endmodule : testbench
